/* File: design/jcc_device.sv */
// codec control register bank with line buffer port
`default_nettype none
`include "jcc_consts.svh"
module jcc_device
    import jcc_pkg::*;
#(
    parameter bit SECOND_INST = 1'b0
)
(
    input wire logic pclk,
    input wire logic presetn,
    jcc_if.dev link,
    input wire logic [2:0] capture_mode,
    input wire logic op_done,
    input wire logic dec_error,
    input wire logic [1:0] dec_fmt,
    input wire logic [15:0] dec_vsize,
    input wire logic [15:0] dec_hsize,
    input wire logic [31:0] lb_rdata,
    output logic core_start,
    output logic core_reset,
    output logic core_busy,
    output logic codec_end_flag,
    output logic decode_sel,
    output logic [1:0] yuv_format,
    output logic marker_insert,
    output logic [2:0] quant_sel,
    output logic [5:0] huff_sel,
    output logic [15:0] restart_interval,
    output logic restart_marker_en,
    output logic [15:0] image_height,
    output logic [15:0] image_width,
    output logic [1:0] error_mode,
    output logic correct_en,
    output logic [16:0] lb_base_addr,
    output logic [31:0] lb_ahb_addr,
    output logic lb_read,
    output logic lb_write,
    output logic [31:0] lb_wdata
);
    jcc_dev_t s_q; // registered state
    jcc_dev_t s_d; // next state
    logic take; // a new link request is taken
    logic lbk; // line buffer bank selected
    logic [11:0] ofs; // offset inside bank
    logic size_hidden; // capture mode hides sizes
    logic enc; // encoding selected

    // low byte of a link write
    function automatic logic [7:0] lo8(input logic [31:0] d);
        return d[7:0];
    endfunction

    assign take = link.req & ~s_q.ack;
    assign lbk = link.addr[12];
    assign ofs = link.addr[11:0];
    assign size_hidden = (capture_mode == `JCC_CAP_A) ||
                         (capture_mode == `JCC_CAP_B);
    assign enc = ~s_q.dec;

    assign link.ack = s_q.ack;
    assign link.rdata = s_q.rdata;
    assign core_start = s_q.start;
    assign core_reset = s_q.crst;
    assign core_busy = s_q.busy;
    assign codec_end_flag = s_q.endf;
    assign decode_sel = s_q.dec;
    assign yuv_format = s_q.fmt;
    assign marker_insert = s_q.marker & enc;
    assign quant_sel = enc ? s_q.qsel : 3'h0;
    assign huff_sel = enc ? s_q.hsel : 6'h0;
    assign restart_interval = enc ? s_q.rsti : 16'h0;
    assign restart_marker_en = enc & (s_q.rsti != 16'h0);
    assign image_height = s_q.vsz;
    assign image_width = s_q.hsz;
    assign error_mode = s_q.dec ? s_q.errm : 2'h0;
    assign correct_en = s_q.dec & (s_q.errm == `JCC_ERR_FIX);
    assign lb_base_addr = {s_q.lbofs, 10'h000};
    assign lb_ahb_addr = SECOND_INST ? `JCC_LB_AHB_SECOND
                                     : `JCC_LB_AHB_FIRST;
    assign lb_read = s_q.lbrd;
    assign lb_write = s_q.lbwr;
    assign lb_wdata = s_q.lbwd;

    ////////////////////////////////////////////////////////////////////
    // next state: link decode, command handling, core events
    always_comb begin
        s_d = s_q;
        s_d.ack = take;
        s_d.start = 1'b0;
        s_d.crst = 1'b0;
        s_d.lbrd = 1'b0;
        s_d.lbwr = 1'b0;
        // core finished: drop busy, report decoded image
        if (op_done && s_q.busy) begin
            s_d.busy = 1'b0;
            if (s_q.dec) begin
                s_d.fmt = dec_fmt;
                s_d.vsz = dec_vsize;
                s_d.hsz = dec_hsize;
            end
        end
        if (take && link.we) begin
            if (!lbk) begin
                case (ofs)
                    `JCC_MODE_OFS: begin
                        s_d.marker = link.wdata[`JCC_MODE_MARKER];
                        s_d.dec = link.wdata[`JCC_MODE_DEC];
                        s_d.fmt = link.wdata[1:0];
                    end
                    `JCC_CMD_OFS: begin
                        if (link.wdata[`JCC_CMD_RESET]) begin
                            // core reset keeps every setting
                            s_d.crst = 1'b1;
                            s_d.busy = 1'b0;
                            s_d.lock = 1'b0;
                        end else if (link.wdata[`JCC_CMD_START] &&
                                     !s_q.busy && !s_q.lock) begin
                            // start refused while running or locked
                            s_d.start = 1'b1;
                            s_d.busy = 1'b1;
                        end
                    end
                    `JCC_QSEL_OFS: s_d.qsel = link.wdata[2:0];
                    `JCC_HSEL_OFS: s_d.hsel = link.wdata[5:0];
                    `JCC_RSTI_HI_OFS: s_d.rsti[15:8] = lo8(link.wdata);
                    `JCC_RSTI_LO_OFS: s_d.rsti[7:0] = lo8(link.wdata);
                    `JCC_VSZ_HI_OFS: s_d.vsz[15:8] = lo8(link.wdata);
                    `JCC_VSZ_LO_OFS: s_d.vsz[7:0] = lo8(link.wdata);
                    `JCC_HSZ_HI_OFS: s_d.hsz[15:8] = lo8(link.wdata);
                    `JCC_HSZ_LO_OFS: s_d.hsz[7:0] = lo8(link.wdata);
                    `JCC_ERRM_OFS: s_d.errm = link.wdata[1:0];
                    default: ;
                endcase
            end else begin
                case (ofs)
                    `JCC_LBOFS_OFS: s_d.lbofs = link.wdata[6:0];
                    `JCC_LBPORT_OFS: begin
                        s_d.lbwr = 1'b1;
                        s_d.lbwd = link.wdata;
                    end
                    default: ;
                endcase
            end
        end
        // stop on error only in the stop code while decoding; sits after the
        // command decode so that a stop in a reset cycle still sets the lock
        if (dec_error && s_q.busy && s_q.dec && s_q.errm == `JCC_ERR_STOP) begin
            s_d.busy = 1'b0;
            s_d.lock = 1'b1;
        end
        // read path; unmapped and write-only read as zero
        if (take && !link.we) begin
            s_d.rdata = 32'h0;
            if (!lbk) begin
                case (ofs)
                    `JCC_MODE_OFS: s_d.rdata = {28'h0, s_q.marker, s_q.dec, s_q.fmt};
                    `JCC_STAT_OFS: s_d.rdata = {31'h0, s_q.busy};
                    `JCC_QSEL_OFS: s_d.rdata = {29'h0, s_q.qsel};
                    `JCC_HSEL_OFS: s_d.rdata = {26'h0, s_q.hsel};
                    `JCC_RSTI_HI_OFS: s_d.rdata = {24'h0, s_q.rsti[15:8]};
                    `JCC_RSTI_LO_OFS: s_d.rdata = {24'h0, s_q.rsti[7:0]};
                    `JCC_VSZ_HI_OFS: begin
                        if (!size_hidden) s_d.rdata = {24'h0, s_q.vsz[15:8]};
                    end
                    `JCC_VSZ_LO_OFS: begin
                        if (!size_hidden) s_d.rdata = {24'h0, s_q.vsz[7:0]};
                    end
                    `JCC_HSZ_HI_OFS: begin
                        if (!size_hidden) s_d.rdata = {24'h0, s_q.hsz[15:8]};
                    end
                    `JCC_HSZ_LO_OFS: begin
                        if (!size_hidden) s_d.rdata = {24'h0, s_q.hsz[7:0]};
                    end
                    `JCC_ERRM_OFS: s_d.rdata = {30'h0, s_q.errm};
                    default: ;
                endcase
            end else begin
                case (ofs)
                    `JCC_LBOFS_OFS: s_d.rdata = {25'h0, s_q.lbofs};
                    `JCC_LBPORT_OFS: begin
                        s_d.rdata = lb_rdata;
                        s_d.lbrd = 1'b1;
                    end
                    default: ;
                endcase
            end
        end
        // end flag: status read clears, a new end event wins
        if (take && !link.we && !lbk && ofs == `JCC_STAT_OFS) begin
            s_d.endf = 1'b0;
        end
        if ((op_done && s_q.busy) ||
            (dec_error && s_q.busy && s_q.dec && s_q.errm == `JCC_ERR_STOP)) begin
            s_d.endf = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.lbofs <= `JCC_LBOFS_RST;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // jcc_device
`default_nettype wire

/* File: design/jcc_consts.svh */
// constants shared by the codec control register bank and its controller
`ifndef JCC_CONSTS_SVH
`define JCC_CONSTS_SVH
// link register offsets, codec bank
`define JCC_MODE_OFS 12'h000
`define JCC_CMD_OFS 12'h004
`define JCC_STAT_OFS 12'h008
`define JCC_QSEL_OFS 12'h00C
`define JCC_HSEL_OFS 12'h010
`define JCC_RSTI_HI_OFS 12'h014
`define JCC_RSTI_LO_OFS 12'h018
`define JCC_VSZ_LO_OFS 12'h020
`define JCC_HSZ_HI_OFS 12'h024
`define JCC_HSZ_LO_OFS 12'h028
`define JCC_ERRM_OFS 12'h038
`define JCC_VSZ_HI_OFS 12'h10C
// link register offsets, line buffer bank
`define JCC_LBOFS_OFS 12'h0A4
`define JCC_LBPORT_OFS 12'h0C0
// bus addresses of the line buffer port per instance
`define JCC_LB_AHB_FIRST 32'hE00000C0
`define JCC_LB_AHB_SECOND 32'hD00000C0
// field positions
`define JCC_MODE_MARKER 3
`define JCC_MODE_DEC 2
`define JCC_CMD_RESET 7
`define JCC_CMD_START 0
// reset values
`define JCC_LBOFS_RST 7'h20
// error handling codes
`define JCC_ERR_STOP 2'h1
`define JCC_ERR_FIX 2'h2
// capture mode codes of the register bank capture_mode input
`define JCC_CAP_A 3'h3
`define JCC_CAP_B 3'h7
// controller apb offsets
`define JCC_H_CTRL 12'h000
`define JCC_H_ADDR 12'h004
`define JCC_H_WDATA 12'h008
`define JCC_H_RDATA 12'h00C
`define JCC_H_STAT 12'h010
`endif

/* File: design/jcc_pkg.sv */
// types shared by the codec control register bank and its controller
`default_nettype none
package jcc_pkg;
    // state of the register bank
    typedef struct packed {
        logic marker;
        logic dec;
        logic [1:0] fmt;
        logic [2:0] qsel;
        logic [5:0] hsel;
        logic [15:0] rsti;
        logic [15:0] vsz;
        logic [15:0] hsz;
        logic [1:0] errm;
        logic [6:0] lbofs;
        logic busy;
        logic lock;
        logic endf;
        logic ack;
        logic [31:0] rdata;
        logic start;
        logic crst;
        logic lbrd;
        logic lbwr;
        logic [31:0] lbwd;
    } jcc_dev_t;
    // controller link phases
    typedef enum logic {JCC_IDLE, JCC_WAIT} jcc_phase_t;
    // state of the controller
    typedef struct packed {
        jcc_phase_t phase;
        logic dir_wr;
        logic [12:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic done;
        logic req;
        logic [31:0] prdata;
        logic pslverr;
    } jcc_host_t;
endpackage
`default_nettype wire

/* File: design/jcc_if.sv */
// register link between the controller and the codec register bank
`default_nettype none
interface jcc_if;
    logic req; // request held until ack
    logic we; // 1 write, 0 read
    logic [12:0] addr; // bit 12 selects the line buffer bank
    logic [31:0] wdata; // write data
    logic ack; // one-cycle answer
    logic [31:0] rdata; // read data, valid with ack
    modport dev (input req, we, addr, wdata, output ack, rdata);
    modport host (output req, we, addr, wdata, input ack, rdata);
endinterface
`default_nettype wire

/* File: design/jcc_host.sv */
// apb controller that issues register transfers to the codec bank
`default_nettype none
`include "jcc_consts.svh"
module jcc_host
    import jcc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    jcc_if.host link
);
    jcc_host_t s_q; // registered state
    jcc_host_t s_d; // next state
    logic setup; // apb setup cycle
    logic wr_acc; // apb write access cycle

    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;
    assign pready = 1'b1;
    assign prdata = s_q.prdata;
    assign pslverr = s_q.pslverr;
    assign link.req = s_q.req;
    assign link.we = s_q.dir_wr;
    assign link.addr = s_q.addr;
    assign link.wdata = s_q.wdata;

    ////////////////////////////////////////////////////////////////////
    // next state: apb decode and link sequencing
    always_comb begin
        s_d = s_q;
        if (setup) begin
            // read data and error prepared in setup, shown in access
            s_d.pslverr = 1'b0;
            case (paddr)
                `JCC_H_CTRL: s_d.prdata = {31'h0, s_q.dir_wr};
                `JCC_H_ADDR: s_d.prdata = {19'h0, s_q.addr};
                `JCC_H_WDATA: s_d.prdata = s_q.wdata;
                `JCC_H_RDATA: s_d.prdata = s_q.rdata;
                `JCC_H_STAT: s_d.prdata = {30'h0, s_q.done, s_q.req};
                default: begin
                    s_d.prdata = 32'h0;
                    s_d.pslverr = 1'b1;
                end
            endcase
        end
        if (wr_acc) begin
            case (paddr)
                `JCC_H_CTRL: begin
                    // go bit ignored while a transfer is open
                    if (s_q.phase == JCC_IDLE && pwdata[0]) begin
                        s_d.dir_wr = pwdata[1];
                        s_d.req = 1'b1;
                        s_d.phase = JCC_WAIT;
                    end
                end
                `JCC_H_ADDR: begin
                    if (s_q.phase == JCC_IDLE) s_d.addr = pwdata[12:0];
                end
                `JCC_H_WDATA: begin
                    if (s_q.phase == JCC_IDLE) s_d.wdata = pwdata;
                end
                `JCC_H_STAT: begin
                    if (pwdata[1]) s_d.done = 1'b0;
                end
                default: ;
            endcase
        end
        case (s_q.phase)
            JCC_IDLE: ;
            JCC_WAIT: begin
                // answer closes the transfer; done set wins over clear
                if (link.ack) begin
                    s_d.req = 1'b0;
                    s_d.done = 1'b1;
                    s_d.phase = JCC_IDLE;
                    if (!s_q.dir_wr) s_d.rdata = link.rdata;
                end
            end
            default: s_d.phase = JCC_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // jcc_host
`default_nettype wire

/* File: testbench/jcc_link_asserts.sv */
// link protocol checker between the controller and the codec register bank
`default_nettype none
`include "jcc_consts.svh"
module jcc_link_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req,
    input wire logic we,
    input wire logic [12:0] addr,
    input wire logic [31:0] wdata,
    input wire logic ack,
    input wire logic [31:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    // a request the bank has not answered yet
    sequence s_take;
        req && !ack;
    endsequence
    // a read of the command word or of a hole in the map
    sequence s_zero_rd;
        s_take ##0 (!we && (addr == {1'b0, `JCC_CMD_OFS} || addr == 13'h003C));
    endsequence
    ////////////////////////////////////////////////////////////////////////
    property p_ack_one_cycle;
        s_take |=> ack;
    endproperty
    property p_ack_pulse;
        ack |=> !ack;
    endproperty
    property p_ack_needs_req;
        ack |-> req;
    endproperty
    property p_req_drop;
        req && ack |=> !req;
    endproperty
    property p_req_hold;
        s_take |=> req && $stable(we) && $stable(addr) && $stable(wdata);
    endproperty
    property p_req_fall;
        $fell(req) |-> $past(ack);
    endproperty
    property p_zero_read;
        s_zero_rd |=> ack && rdata == 32'h0000_0000;
    endproperty
    property p_rdata_hold;
        $changed(rdata) |-> ack && !we;
    endproperty
    a_ack_one_cycle: assert property (p_ack_one_cycle)
        else $error("link answer late");
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("link answer longer than one cycle");
    a_ack_needs_req: assert property (p_ack_needs_req)
        else $error("link answer without request");
    a_req_drop: assert property (p_req_drop)
        else $error("request kept after answer");
    a_req_hold: assert property (p_req_hold)
        else $error("request changed before answer");
    a_req_fall: assert property (p_req_fall)
        else $error("request dropped without answer");
    a_zero_read: assert property (p_zero_read)
        else $error("command or hole read not zero");
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved outside a read answer");
endmodule // jcc_link_asserts
`default_nettype wire

/* File: testbench/jpeg_codec_control_regs_tb_top.sv */
// testbench joining the apb controller and the codec register bank
`default_nettype none
`include "jcc_consts.svh"
module jpeg_codec_control_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, last_err;
    logic [2:0] capture_mode = 3'h0;
    logic op_done = 1'b0;
    logic dec_error = 1'b0;
    logic [1:0] dec_fmt = 2'h0;
    logic [15:0] dec_vsize = 16'h0;
    logic [15:0] dec_hsize = 16'h0;
    logic [31:0] lb_rdata = 32'h0;
    logic core_start, core_reset, core_busy, codec_end_flag, decode_sel, marker_insert;
    logic restart_marker_en, correct_en, lb_read, lb_write;
    logic [1:0] yuv_format, error_mode;
    logic [2:0] quant_sel;
    logic [5:0] huff_sel;
    logic [15:0] restart_interval, image_height, image_width;
    logic [16:0] lb_base_addr;
    logic [31:0] lb_ahb_addr, lb_wdata, rd;
    int err_total = 0;
    int check_count = 0;
    int starts = 0;
    int resets = 0;
    int lb_reads = 0;
    int lb_writes = 0;
    // readable words of the codec bank except status, all zero after reset
    logic [11:0] ofs [10] = '{`JCC_MODE_OFS, `JCC_QSEL_OFS, `JCC_HSEL_OFS, `JCC_RSTI_HI_OFS,
        `JCC_RSTI_LO_OFS, `JCC_VSZ_LO_OFS, `JCC_HSZ_HI_OFS, `JCC_HSZ_LO_OFS, `JCC_ERRM_OFS,
        `JCC_VSZ_HI_OFS};
    // encode setup: offset and value pairs
    logic [11:0] wofs [8] = '{`JCC_QSEL_OFS, `JCC_HSEL_OFS, `JCC_RSTI_HI_OFS, `JCC_RSTI_LO_OFS,
        `JCC_VSZ_HI_OFS, `JCC_VSZ_LO_OFS, `JCC_HSZ_HI_OFS, `JCC_HSZ_LO_OFS};
    logic [31:0] wval [8] = '{32'h5, 32'h2A, 32'h12, 32'h34, 32'h01, 32'hE0, 32'h02, 32'h80};
    always #50 pclk = ~pclk;
    jcc_if jcc_if_i ();
    jcc_host jcc_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(jcc_if_i.host));
    jcc_device jcc_device_i (.pclk(pclk), .presetn(presetn), .link(jcc_if_i.dev),
        .capture_mode(capture_mode), .op_done(op_done), .dec_error(dec_error),
        .dec_fmt(dec_fmt), .dec_vsize(dec_vsize), .dec_hsize(dec_hsize), .lb_rdata(lb_rdata),
        .core_start(core_start), .core_reset(core_reset), .core_busy(core_busy),
        .codec_end_flag(codec_end_flag), .decode_sel(decode_sel), .yuv_format(yuv_format),
        .marker_insert(marker_insert), .quant_sel(quant_sel), .huff_sel(huff_sel),
        .restart_interval(restart_interval), .restart_marker_en(restart_marker_en),
        .image_height(image_height), .image_width(image_width), .error_mode(error_mode),
        .correct_en(correct_en), .lb_base_addr(lb_base_addr), .lb_ahb_addr(lb_ahb_addr),
        .lb_read(lb_read), .lb_write(lb_write), .lb_wdata(lb_wdata));
    jcc_link_asserts jcc_link_asserts_i (.pclk(pclk), .presetn(presetn), .req(jcc_if_i.req),
        .we(jcc_if_i.we), .addr(jcc_if_i.addr), .wdata(jcc_if_i.wdata), .ack(jcc_if_i.ack),
        .rdata(jcc_if_i.rdata));
    ////////////////////////////////////////////////////////////////////////
    // count core command pulses and line buffer port strobes
    always @(posedge pclk) begin
        if (core_start === 1'b1) starts++;
        if (core_reset === 1'b1) resets++;
        if (lb_read === 1'b1) lb_reads++;
        if (lb_write === 1'b1) lb_writes++;
    end
    // verdict and end of run
    task automatic complete_run;
        if (err_total == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // one comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one apb transfer, read data left in rd
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_total++;
            complete_run();
        end
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one bank access through the controller, bounded wait on done
    task automatic link(input logic w, input logic bank, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        apb(1'b1, `JCC_H_ADDR, {19'h0, bank, a});
        apb(1'b1, `JCC_H_WDATA, d);
        apb(1'b1, `JCC_H_CTRL, {30'h0, w, 1'b1});
        n = 0;
        do begin
            apb(1'b0, `JCC_H_STAT, 32'h0);
            n++;
        end while (rd[1] !== 1'b1 && n < 20);
        if (rd[1] !== 1'b1) begin
            err_total++;
            complete_run();
        end
        apb(1'b1, `JCC_H_STAT, 32'h2);
        if (!w) apb(1'b0, `JCC_H_RDATA, 32'h0);
    endtask
    // one core event pulse, then let outputs settle
    task automatic ev(input logic err);
        @(posedge pclk);
        if (err) dec_error <= 1'b1;
        else op_done <= 1'b1;
        @(posedge pclk);
        op_done <= 1'b0;
        dec_error <= 1'b0;
        @(negedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk(lb_base_addr, {`JCC_LBOFS_RST, 10'h000}, "lb base");
        chk(lb_ahb_addr, `JCC_LB_AHB_FIRST, "lb bus address");
        foreach (ofs[i]) begin
            link(1'b0, 1'b0, ofs[i], 32'h0);
            chk(rd, 32'h0, "reset value");
        end
        link(1'b0, 1'b1, `JCC_LBOFS_OFS, 32'h0);
        chk(rd, 32'h20, "lb offset reset");
        link(1'b1, 1'b1, `JCC_LBOFS_OFS, 32'h5);
        chk(lb_base_addr, 17'h1400, "lb base moved");
        // encode setup
        link(1'b1, 1'b0, `JCC_MODE_OFS, 32'h9);
        chk(marker_insert, 1'b1, "marker on");
        chk(decode_sel, 1'b0, "encode selected");
        foreach (wofs[i]) link(1'b1, 1'b0, wofs[i], wval[i]);
        chk(quant_sel, 3'h5, "quant select");
        chk(huff_sel, 6'h2A, "huffman select");
        chk(restart_interval, 16'h1234, "interval");
        chk(restart_marker_en, 1'b1, "markers on");
        chk(image_height, 16'h01E0, "height");
        chk(image_width, 16'h0280, "width");
        for (int f = 0; f < 4; f++) begin
            link(1'b1, 1'b0, `JCC_MODE_OFS, f); // no encode start here
            chk(yuv_format, f, "format");
            chk(marker_insert, 1'b0, "marker off");
        end
        // zero interval in encode: no markers, zero interval value
        link(1'b1, 1'b0, `JCC_RSTI_HI_OFS, 32'h0);
        link(1'b1, 1'b0, `JCC_RSTI_LO_OFS, 32'h0);
        chk({restart_marker_en, restart_interval}, 32'h0, "zero interval");
        link(1'b1, 1'b0, `JCC_RSTI_LO_OFS, 32'h34);
        // decode hides encode-only settings
        link(1'b1, 1'b0, `JCC_MODE_OFS, 32'hC);
        chk(marker_insert, 1'b0, "marker in decode");
        chk(decode_sel, 1'b1, "decode selected");
        chk({quant_sel, huff_sel, restart_interval}, 32'h0, "encode-only hidden");
        link(1'b1, 1'b0, `JCC_ERRM_OFS, 32'h2);
        chk({correct_en, error_mode}, 32'h6, "correct mode");
        // decode run ends with results
        dec_fmt <= 2'h2;
        dec_vsize <= 16'h0123;
        dec_hsize <= 16'h0456;
        link(1'b1, 1'b0, `JCC_CMD_OFS, 32'h1);
        chk({starts[30:0], core_busy}, 32'h3, "started");
        link(1'b0, 1'b0, `JCC_STAT_OFS, 32'h0);
        chk(rd, 32'h1, "status busy");
        ev(1'b0);
        chk({core_busy, codec_end_flag, yuv_format}, 32'h6, "end of decode");
        chk({image_height, image_width}, 32'h0123_0456, "decoded size");
        link(1'b0, 1'b0, `JCC_STAT_OFS, 32'h0);
        chk(rd, 32'h0, "status idle");
        chk(codec_end_flag, 1'b0, "end flag cleared");
        // stop on error, then core reset
        link(1'b1, 1'b0, `JCC_ERRM_OFS, 32'h1);
        chk({correct_en, error_mode}, 32'h1, "stop mode");
        link(1'b1, 1'b0, `JCC_CMD_OFS, 32'h1);
        ev(1'b1);
        chk({core_busy, codec_end_flag}, 32'h1, "stopped on error");
        link(1'b1, 1'b0, `JCC_CMD_OFS, 32'h1);
        chk({starts[30:0], core_busy}, 32'h4, "start locked");
        link(1'b1, 1'b0, `JCC_CMD_OFS, 32'h81);
        chk({resets[3:0], starts[3:0]}, 32'h12, "reset wins");
        link(1'b1, 1'b0, `JCC_CMD_OFS, 32'h1);
        link(1'b1, 1'b0, `JCC_CMD_OFS, 32'h1);
        chk({starts[30:0], core_busy}, 32'h7, "restart, busy start ignored");
        link(1'b0, 1'b0, `JCC_MODE_OFS, 32'h0);
        chk(rd, 32'hE, "mode kept over reset");
        ev(1'b0);
        // capture mode hides sizes but takes writes
        for (int m = 3; m < 8; m += 4) begin
            capture_mode <= 3'(m);
            link(1'b0, 1'b0, `JCC_HSZ_LO_OFS, 32'h0);
            chk(rd, 32'h0, "size read in capture");
        end
        link(1'b1, 1'b0, `JCC_VSZ_LO_OFS, 32'h77);
        chk(image_height, 16'h0177, "size write in capture");
        capture_mode <= 3'h0;
        link(1'b0, 1'b0, `JCC_HSZ_LO_OFS, 32'h0);
        chk(rd, 32'h56, "size read");
        // line buffer port, command read, holes
        lb_rdata <= 32'hA5C3_0F96;
        link(1'b0, 1'b1, `JCC_LBPORT_OFS, 32'h0);
        chk(rd, 32'hA5C3_0F96, "port read");
        chk(lb_reads, 32'h1, "port read strobe");
        link(1'b1, 1'b1, `JCC_LBPORT_OFS, 32'h3C96_5AA5);
        chk(lb_wdata, 32'h3C96_5AA5, "port write data");
        chk(lb_writes, 32'h1, "port write strobe");
        link(1'b0, 1'b0, `JCC_CMD_OFS, 32'h0);
        chk(rd, 32'h0, "command read");
        link(1'b0, 1'b0, 12'h03C, 32'h0);
        chk(rd, 32'h0, "hole read");
        apb(1'b0, 12'h020, 32'h0);
        chk(last_err, 1'b1, "apb hole error");
        complete_run();
    end
endmodule // jpeg_codec_control_regs_tb_top
`default_nettype wire
